// ### pkg/mesh_io_pkg.sv
/*
  Shared constants for the mesh module status and local I/O block:
  clock rate, serial timing, indicator timing, register map and fields.
  Assumes a single 100 MHz clock and a 32-bit Avalon-MM register bus.
*/
package mesh_io_pkg;

  // ****************************************************************
  // Clock and timing.
  // ****************************************************************
  localparam int CLOCK_HZ         = 100_000_000;
  localparam int CYCLES_PER_MS    = CLOCK_HZ / 1000;
  localparam int BAUD_RATE        = 115200;
  localparam int BIT_CYCLES       = CLOCK_HZ / BAUD_RATE;
  localparam int HOLDOFF_MS       = 1000;
  localparam int HOLDOFF_CYCLES   = HOLDOFF_MS * CYCLES_PER_MS;
  localparam int SLOW_HALF_MS     = 500;
  localparam int SLOW_HALF_CYCLES = SLOW_HALF_MS * CYCLES_PER_MS;
  localparam int FAST_HALF_MS     = 100;
  localparam int FAST_HALF_CYCLES = FAST_HALF_MS * CYCLES_PER_MS;
  localparam int PULSE_MS         = 200;
  localparam int PULSE_CYCLES     = PULSE_MS * CYCLES_PER_MS;

  // ****************************************************************
  // Data widths and reset values.
  // ****************************************************************
  localparam int         ADC_BITS      = 10;
  localparam logic [9:0] ADC_FULL_CODE = 10'h3ff;
  localparam logic [7:0] GPIO_RESET    = 8'hff;
  localparam logic [7:0] GPIO_DIR_RESET = 8'h00;

  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [4:0] OFS_CTRL     = 5'h00;
  localparam logic [4:0] OFS_EVENT    = 5'h04;
  localparam logic [4:0] OFS_STATUS   = 5'h08;
  localparam logic [4:0] OFS_GPIO_DIR = 5'h0c;
  localparam logic [4:0] OFS_GPIO_OUT = 5'h10;
  localparam logic [4:0] OFS_GPIO_IN  = 5'h14;
  localparam logic [4:0] OFS_ADC      = 5'h18;
  localparam logic [4:0] OFS_UART     = 5'h1c;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int CTRL_END_NODE  = 0;
  localparam int CTRL_CMD_MODE  = 1;
  localparam int EV_NET_OK      = 0;
  localparam int EV_NET_FAIL    = 1;
  localparam int EV_BIND_OK     = 2;
  localparam int EV_BIND_FAIL   = 3;
  localparam int EV_TX_OK       = 4;
  localparam int EV_TX_FAIL     = 5;
  localparam int EV_SLEEP       = 6;
  localparam int EV_WAKE        = 7;
  localparam int EV_KEY_CLEAR   = 8;

  // Pattern driven on the status output.
  typedef enum logic [2:0] {
    PAT_LOW  = 3'b000,
    PAT_SLOW = 3'b001,
    PAT_FAST = 3'b010,
    PAT_HIGH = 3'b011
  } pattern_e;

endpackage

// ### design/sync_2ff.sv
/*
  Two-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level from a pin; bits are not coherent.
*/
`timescale 1ns/1ps
module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock) begin
    if (rst) begin
      stage_one <= INIT;
      sync_out  <= INIT;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule

// ### design/rate_divider.sv
/*
  Free-running divider that emits a one-cycle enable pulse every DIVIDE
  cycles while run is high. Assumes DIVIDE is at least one.
*/
`timescale 1ns/1ps
module rate_divider #(
  parameter int DIVIDE = 2
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);

  localparam int W = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
  localparam logic [W-1:0] LAST = W'(DIVIDE - 1);

  logic [W-1:0] count;

  // Count while running; restart whenever stopped.
  always_ff @(posedge clock) begin
    if (rst || !run) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= (count == LAST);
      count <= (count == LAST) ? '0 : count + 1'b1;
    end
  end

endmodule

// ### design/module_status_and_local_io.sv
/*
  Status and local I/O of a wireless mesh module: serial link, reset pin,
  analog code capture, indicator outputs, key input with sleep hold-off
  and an eight-bit port. Firmware drives it over Avalon-MM.
  Assumes all pins are asynchronous and the converter is on this clock.
*/
`timescale 1ns/1ps
module module_status_and_local_io
  import mesh_io_pkg::*;
#(
  parameter int SLOW_CYCLES    = SLOW_HALF_CYCLES,
  parameter int FAST_CYCLES    = FAST_HALF_CYCLES,
  parameter int PULSE_LEN      = PULSE_CYCLES,
  parameter int HOLDOFF_LEN    = HOLDOFF_CYCLES,
  parameter int UART_BIT_LEN   = BIT_CYCLES
) (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic [4:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  input  wire logic [ADC_BITS-1:0] adc_code,
  input  wire logic                adc_valid,
  output logic                     uart_tx,
  input  wire logic                uart_rx,
  input  wire logic                reset_n,
  output logic                     soft_reset,
  output logic                     status_led,
  output logic                     error_led,
  output logic                     ok_led,
  input  wire logic                key_n,
  output logic                     low_power,
  input  wire logic [7:0]          gpio_in,
  output logic      [7:0]          gpio_out,
  output logic      [7:0]          gpio_oe
);

  // ****************************************************************
  // Pin synchronisers and local reset.
  // ****************************************************************
  logic [10:0] pins_sync;
  logic        rx_s;
  logic        reset_n_s;
  logic        key_n_s;
  logic [7:0]  gpio_s;
  logic        lrst;

  sync_2ff #(.WIDTH(11), .INIT(11'h7ff)) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({uart_rx, reset_n, key_n, gpio_in}),
    .sync_out (pins_sync)
  );

  // Split the synchronised pins; a low reset pin holds the block in reset.
  assign rx_s       = pins_sync[10];
  assign reset_n_s  = pins_sync[9];
  assign key_n_s    = pins_sync[8];
  assign gpio_s     = pins_sync[7:0];
  assign lrst       = rst | ~reset_n_s;
  assign soft_reset = ~reset_n_s;

  // ****************************************************************
  // Bus slave: one wait state, or more for a serial data write while the transmitter is busy.
  // ****************************************************************
  logic        ack;
  logic        tx_busy;
  logic        req;
  logic        tx_stall;
  logic        wr_ev;
  logic [31:0] rd_mux;
  logic        end_node;
  logic        cmd_mode;
  logic [7:0]  gpio_dir;
  logic [7:0]  gpio_val;
  logic [9:0]  adc_value;
  logic [7:0]  rx_data;
  logic        rx_full;
  logic        key_event;
  logic        sleeping;
  logic [8:0]  ev;

  // Decode; a write to the serial data register waits for the shifter.
  assign req         = read | write;
  assign tx_stall    = write & (address == OFS_UART) & tx_busy;
  assign waitrequest = req & ~ack;
  assign wr_ev       = write & ack & (address == OFS_EVENT);
  assign ev          = wr_ev ? writedata[8:0] : 9'h000;

  // Read multiplexer; unmapped offsets read as zero.
  always_comb begin
    case (address)
      OFS_CTRL:     rd_mux = {30'h0, cmd_mode, end_node};
      OFS_STATUS:   rd_mux = {24'h0, rx_full, key_event, ~key_n_s, sleeping,
                              error_led, ok_led, status_led, tx_busy};
      OFS_GPIO_DIR: rd_mux = {24'h0, gpio_dir};
      OFS_GPIO_OUT: rd_mux = {24'h0, gpio_val};
      OFS_GPIO_IN:  rd_mux = {24'h0, gpio_s};
      OFS_ADC:      rd_mux = {22'h0, adc_value};
      OFS_UART:     rd_mux = {23'h0, rx_full, rx_data};
      default:      rd_mux = 32'h0;
    endcase
  end

  // Acknowledge one cycle after the request; data stands with the ack.
  always_ff @(posedge clock) begin
    if (lrst) begin
      ack      <= 1'b0;
      readdata <= 32'h0;
    end else begin
      ack <= req & ~ack & ~tx_stall;
      if (read && !ack) begin
        readdata <= rd_mux;
      end
    end
  end

  // Writable configuration.
  always_ff @(posedge clock) begin
    if (lrst) begin
      end_node <= 1'b0;
      cmd_mode <= 1'b0;
      gpio_dir <= GPIO_DIR_RESET;
      gpio_val <= GPIO_RESET;
    end else if (write && ack) begin
      if (address == OFS_CTRL) begin
        end_node <= writedata[CTRL_END_NODE];
        cmd_mode <= writedata[CTRL_CMD_MODE];
      end
      if (address == OFS_GPIO_DIR) begin
        gpio_dir <= writedata[7:0];
      end
      if (address == OFS_GPIO_OUT) begin
        gpio_val <= writedata[7:0];
      end
    end
  end

  // Port pins follow the stored value where configured as output.
  assign gpio_out = gpio_val;
  assign gpio_oe  = gpio_dir;

  // Latest converter code, already scaled 000..3ff over the input range.
  always_ff @(posedge clock) begin
    if (lrst) begin
      adc_value <= 10'h000;
    end else if (adc_valid) begin
      adc_value <= adc_code;
    end
  end

  // ****************************************************************
  // Serial transmitter and receiver, 8-N-1.
  // ****************************************************************
  localparam int BW = $clog2(UART_BIT_LEN + 1);
  logic [BW-1:0] tx_cnt;
  logic [3:0]    tx_bits;
  logic [9:0]    tx_shift;
  logic [BW-1:0] rx_cnt;
  logic [3:0]    rx_bits;
  logic [7:0]    rx_shift;
  logic          rx_busy;
  logic          tx_load;
  logic          rx_done;
  logic          rx_take;

  assign tx_busy = (tx_bits != 4'd0);
  assign tx_load = write & ack & (address == OFS_UART);
  assign rx_take = read & ack & (address == OFS_UART);
  assign uart_tx = tx_shift[0];

  // Shift out start, eight data bits and stop, low bit first.
  always_ff @(posedge clock) begin
    if (lrst) begin
      tx_shift <= 10'h3ff;
      tx_bits  <= 4'd0;
      tx_cnt   <= '0;
    end else if (tx_load) begin
      tx_shift <= {1'b1, writedata[7:0], 1'b0};
      tx_bits  <= 4'd10;
      tx_cnt   <= BW'(UART_BIT_LEN - 1);
    end else if (tx_busy) begin
      if (tx_cnt == '0) begin
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_bits  <= tx_bits - 4'd1;
        tx_cnt   <= BW'(UART_BIT_LEN - 1);
      end else begin
        tx_cnt <= tx_cnt - 1'b1;
      end
    end
  end

  // Sample each bit at its middle after a start edge.
  always_ff @(posedge clock) begin
    if (lrst) begin
      rx_busy  <= 1'b0;
      rx_bits  <= 4'd0;
      rx_cnt   <= '0;
      rx_shift <= 8'h00;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!rx_busy) begin
        if (!rx_s) begin
          rx_busy <= 1'b1;
          rx_bits <= 4'd0;
          rx_cnt  <= BW'(UART_BIT_LEN / 2);
        end
      end else if (rx_cnt != '0) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else begin
        rx_cnt  <= BW'(UART_BIT_LEN - 1);
        rx_bits <= rx_bits + 4'd1;
        if (rx_bits == 4'd0 && rx_s) begin
          rx_busy <= 1'b0; // False start.
        end else if (rx_bits >= 4'd1 && rx_bits <= 4'd8) begin
          rx_shift <= {rx_s, rx_shift[7:1]};
        end else if (rx_bits == 4'd9) begin
          rx_busy <= 1'b0;
          rx_done <= rx_s;
        end
      end
    end
  end

  // Received byte holding register; a new byte wins over a read clear.
  always_ff @(posedge clock) begin
    if (lrst) begin
      rx_data <= 8'h00;
      rx_full <= 1'b0;
    end else if (rx_done) begin
      rx_data <= rx_shift;
      rx_full <= 1'b1;
    end else if (rx_take) begin
      rx_full <= 1'b0;
    end
  end

  // ****************************************************************
  // Key input and sleep hold-off.
  // ****************************************************************
  localparam int HW = $clog2(HOLDOFF_LEN + 1);
  logic [HW-1:0] hold_cnt;
  logic          key_prev;
  logic          key_fall;
  logic          hold_done;
  logic          sleep_pend;

  assign key_fall  = key_prev & ~key_n_s;
  assign hold_done = (hold_cnt == HW'(HOLDOFF_LEN));

  // Key press is latched; a press in the clear cycle keeps the flag.
  always_ff @(posedge clock) begin
    if (lrst) begin
      key_prev  <= 1'b1;
      key_event <= 1'b0;
    end else begin
      key_prev <= key_n_s;
      if (key_fall) begin
        key_event <= 1'b1;
      end else if (ev[EV_KEY_CLEAR]) begin
        key_event <= 1'b0;
      end
    end
  end

  // Release timer restarts while the key is held down.
  always_ff @(posedge clock) begin
    if (lrst || !key_n_s) begin
      hold_cnt <= '0;
    end else if (!hold_done) begin
      hold_cnt <= hold_cnt + 1'b1;
    end
  end

  // An end node sleeps once the key has been released long enough.
  always_ff @(posedge clock) begin
    if (lrst) begin
      sleep_pend <= 1'b0;
      sleeping   <= 1'b0;
    end else if (ev[EV_WAKE] || (sleeping && key_fall)) begin
      sleep_pend <= 1'b0;
      sleeping   <= 1'b0;
    end else if (ev[EV_SLEEP] && end_node) begin
      sleep_pend <= 1'b1;
    end else if (sleep_pend && hold_done && key_n_s) begin
      sleep_pend <= 1'b0;
      sleeping   <= 1'b1;
    end
  end

  assign low_power = sleeping;

  // ****************************************************************
  // Indicator outputs.
  // ****************************************************************
  localparam int PW = $clog2(PULSE_LEN + 1);
  pattern_e  pattern;
  pattern_e  next_pattern;
  logic      slow_tick;
  logic      fast_tick;
  logic      blink;
  logic [PW-1:0] err_cnt;
  logic [PW-1:0] ok_cnt;
  logic      was_sleeping;
  logic      ok_fire;
  logic      err_fire;
  logic      next_status;
  logic      next_error;
  logic      next_ok;

  rate_divider #(.DIVIDE(SLOW_CYCLES)) u_slow (
    .clock (clock),
    .rst   (lrst),
    .run   (pattern == PAT_SLOW),
    .tick  (slow_tick)
  );

  rate_divider #(.DIVIDE(FAST_CYCLES)) u_fast (
    .clock (clock),
    .rst   (lrst),
    .run   (pattern == PAT_FAST),
    .tick  (fast_tick)
  );

  // Result events that start a single pulse.
  assign ok_fire  = ev[EV_NET_OK] | ev[EV_BIND_OK] | ev[EV_TX_OK];
  assign err_fire = ev[EV_NET_FAIL] | ev[EV_TX_FAIL];

  // Next status pattern from wake-up and the network and binding results.
  always_comb begin
    next_pattern = pattern;
    if (was_sleeping && !sleeping) begin
      next_pattern = PAT_HIGH;
    end else if (ev[EV_BIND_OK]) begin
      next_pattern = PAT_HIGH;
    end else if (ev[EV_BIND_FAIL]) begin
      next_pattern = PAT_SLOW;
    end else if (ev[EV_NET_FAIL]) begin
      next_pattern = PAT_FAST;
    end else if (ev[EV_NET_OK]) begin
      next_pattern = PAT_SLOW;
    end
  end

  // Pattern state, blink phase and pulse counters.
  always_ff @(posedge clock) begin
    if (lrst) begin
      pattern      <= PAT_LOW;
      blink        <= 1'b0;
      was_sleeping <= 1'b0;
      err_cnt      <= '0;
      ok_cnt       <= '0;
    end else begin
      pattern      <= next_pattern;
      was_sleeping <= sleeping;
      if (slow_tick || fast_tick) begin
        blink <= ~blink;
      end
      if (err_fire) begin
        err_cnt <= PW'(PULSE_LEN);
      end else if (err_cnt != '0) begin
        err_cnt <= err_cnt - 1'b1;
      end
      if (ok_fire) begin
        ok_cnt <= PW'(PULSE_LEN);
      end else if (ok_cnt != '0) begin
        ok_cnt <= ok_cnt - 1'b1;
      end
    end
  end

  // Output selection: command mode, then sleep, then normal patterns.
  always_comb begin
    if (cmd_mode) begin
      next_status = 1'b0;
      next_error  = 1'b1;
      next_ok     = 1'b1;
    end else if (sleeping) begin
      next_status = 1'b1;
      next_error  = 1'b1;
      next_ok     = 1'b1;
    end else begin
      case (pattern)
        PAT_HIGH: next_status = 1'b1;
        PAT_SLOW: next_status = blink;
        PAT_FAST: next_status = blink;
        default:  next_status = 1'b0;
      endcase
      next_error = (err_cnt != '0);
      next_ok    = (ok_cnt != '0);
    end
  end

  // Indicator pins come straight from flops.
  always_ff @(posedge clock) begin
    if (lrst) begin
      status_led <= 1'b0;
      error_led  <= 1'b0;
      ok_led     <= 1'b0;
    end else begin
      status_led <= next_status;
      error_led  <= next_error;
      ok_led     <= next_ok;
    end
  end

endmodule

// ### verification/status_io_monitor.sv
/*
  Port checker for the status and local I/O block.
  Assumes it is bound to the top module from the bench's top file.
*/
`timescale 1ns/1ps
module status_io_monitor
  import mesh_io_pkg::*;
#(
  parameter int HOLDOFF_LEN = HOLDOFF_CYCLES
) (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [4:0] address,
  input wire logic       write,
  input wire logic       waitrequest,
  input wire logic       uart_tx,
  input wire logic       reset_n,
  input wire logic       soft_reset,
  input wire logic       status_led,
  input wire logic       error_led,
  input wire logic       ok_led,
  input wire logic       key_n,
  input wire logic       low_power,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe
);
  int rel_cnt;

  // Counts cycles of key release at the pin; saturates at the hold-off.
  always_ff @(posedge clock) begin
    if (rst) begin
      rel_cnt <= HOLDOFF_LEN;
    end else if (!key_n) begin
      rel_cnt <= 0;
    end else if (rel_cnt < HOLDOFF_LEN) begin
      rel_cnt <= rel_cnt + 1;
    end
  end

  // ****************************************************************
  // Properties.
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_uart_ack;
    write && !waitrequest && address == OFS_UART;
  endsequence
  sequence s_sleep_in;
    $rose(low_power);
  endsequence

  a_soft_reset_follow: assert property (!reset_n [*3] |-> soft_reset)
    else $error("soft reset not raised by reset pin");
  a_soft_reset_quiet: assert property (soft_reset [*3] |-> !status_led && !error_led && !ok_led && !low_power)
    else $error("outputs active during soft reset");
  a_gpio_reset_ones: assert property ($fell(rst) |-> gpio_out == GPIO_RESET && gpio_oe == GPIO_DIR_RESET)
    else $error("port not at default after reset");
  a_sleep_leds_high: assert property (s_sleep_in |-> ##[0:1] (status_led && error_led && ok_led))
    else $error("indicators not high in sleep");
  a_wake_leds_low: assert property ($fell(low_power) && !soft_reset |-> ##[0:1] (!error_led && !ok_led))
    else $error("error or ok high after wake");
  a_key_holdoff_met: assert property (s_sleep_in |-> rel_cnt >= HOLDOFF_LEN)
    else $error("sleep entered before hold-off");
  a_uart_start_bit: assert property (s_uart_ack |-> ##[1:2] !uart_tx)
    else $error("no start bit after serial write");
  a_oe_has_cause: assert property (!$stable(gpio_oe) |->
    $past(write && !waitrequest && address == OFS_GPIO_DIR) || $past(soft_reset) || soft_reset)
    else $error("port direction changed without a write");
endmodule

// ### verification/host_uart_model.sv
/*
  Host side of the serial link: sends frames to the block, logs frames from it.
  Assumes 8-N-1 framing at BIT_LEN clocks a bit on an idle-high line.
*/
`timescale 1ns/1ps
module host_uart_model #(
  parameter int BIT_LEN = 8
) (
  input  wire logic clock,
  input  wire logic uart_tx,
  output logic      uart_rx
);
  logic [7:0] rx_byte;
  logic [7:0] rx_log[$];

  // No resets go over the link; the bench alone drives the reset pin.
  // No firmware program pin exists here, so it stays unconnected.
  // Sends a frame: low start bit, data LSB first, high stop bit.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      uart_rx <= f[i];
      repeat (BIT_LEN) @(posedge clock);
    end
  endtask

  // Samples each bit in its middle and logs the byte at the stop bit.
  initial begin
    uart_rx = 1'b1;
    rx_byte = 8'h00;
    forever begin
      @(negedge uart_tx);
      repeat (BIT_LEN / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_LEN) @(posedge clock);
        rx_byte[i] = uart_tx;
      end
      repeat (BIT_LEN) @(posedge clock);
      rx_log.push_back(rx_byte);
    end
  end
endmodule

// ### verification/tb.sv
/*
  Self-checking bench for the status and local I/O block.
  Assumes shortened timing parameters and an idle-high serial host.
*/
`timescale 1ns/1ps
module tb
  import mesh_io_pkg::*;
;
  localparam int SLOW = 40;
  localparam int FAST = 10;
  localparam int PLS  = 8;
  localparam int HOLD = 50;
  localparam int BITL = 8;
  logic        clock, rst, read, write, adc_valid, uart_rx, reset_n, key_n;
  logic        waitrequest, uart_tx, soft_reset, status_led, error_led, ok_led, low_power;
  logic [4:0]  address;
  logic [31:0] writedata, readdata, rd;
  logic [9:0]  adc_code;
  logic [7:0]  gpio_in, gpio_out, gpio_oe, gpio_sw;
  int          err_total, check_count, n;
  int          ev[5] = '{EV_TX_OK, EV_TX_FAIL, EV_NET_OK, EV_NET_FAIL, EV_BIND_OK};
  int          pl[5] = '{2, 1, 2, 1, 2};
  int          se[3] = '{EV_NET_OK, EV_NET_FAIL, EV_BIND_FAIL};
  int          sl[3] = '{SLOW, FAST, SLOW};
  logic [9:0]  ac[3] = '{10'h000, 10'h3ff, 10'h155};

  // Port pins carry the block's level where it drives, the switch level elsewhere.
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & gpio_sw);

  module_status_and_local_io #(.SLOW_CYCLES(SLOW), .FAST_CYCLES(FAST), .PULSE_LEN(PLS),
    .HOLDOFF_LEN(HOLD), .UART_BIT_LEN(BITL)) module_status_and_local_io_inst (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .adc_code(adc_code), .adc_valid(adc_valid), .uart_tx(uart_tx), .uart_rx(uart_rx),
    .reset_n(reset_n), .soft_reset(soft_reset), .status_led(status_led), .error_led(error_led),
    .ok_led(ok_led), .key_n(key_n), .low_power(low_power), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe));

  host_uart_model #(.BIT_LEN(BITL)) host_uart_model_inst (
    .clock(clock), .uart_tx(uart_tx), .uart_rx(uart_rx));

  // ****************************************************************
  // Tasks.
  // ****************************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clock);
  endtask

  // One bus transfer, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clock);
      k++;
    end while (waitrequest !== 1'b0 && k < 2000);
    rd = readdata;
    if (k >= 2000) err_total++;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rchk(input string what, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask

  function automatic logic led(input int i);
    return (i == 0) ? status_led : (i == 1) ? error_led : ok_led;
  endfunction

  // Skips any running high phase and counts the cycles of the next one.
  task automatic hi_run(input int i, output int len);
    int k;
    k = 0;
    len = 0;
    while (led(i) === 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
    while (led(i) !== 1'b1 && k < 300) begin
      tick(1);
      k++;
    end
    while (led(i) === 1'b1 && len < 300) begin
      tick(1);
      len++;
    end
  endtask

  // Clock generator.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Watchdog: ends a hung run as a failure.
  initial begin
    tick(20000);
    err_total++;
    give_verdict();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    {rst, read, write, adc_valid, reset_n, key_n} = 6'b100011;
    {address, writedata, adc_code, gpio_sw} = '0;
    gpio_sw = 8'hff;
    err_total = 0;
    check_count = 0;
    tick(16);
    rst <= 1'b0;
    tick(2);
    check("reset_pins", 32'h000ff008, 32'({gpio_out, gpio_oe, uart_tx, status_led, error_led, ok_led}));
    wr(5'h02, 32'hffffffff);
    rchk("unmapped", 5'h02, 32'h0);
    rchk("ctrl", OFS_CTRL, 32'h0);
    rchk("gpio_out_reg", OFS_GPIO_OUT, 32'hff);
    for (int i = 0; i < 3; i++) begin
      adc_code <= ac[i];
      adc_valid <= 1'b1;
      tick(1);
      adc_valid <= 1'b0;
      rchk("adc", OFS_ADC, 32'(ac[i]));
    end
    wr(OFS_GPIO_DIR, 32'h0f);
    wr(OFS_GPIO_OUT, 32'ha5);
    gpio_sw <= 8'h3c;
    tick(4);
    check("gpio_pins", 32'h0fa5, 32'({gpio_oe, gpio_out}));
    rchk("gpio_in", OFS_GPIO_IN, 32'h35);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_EVENT, 32'h1 << ev[i]);
      hi_run(pl[i], n);
      check("pulse_len", PLS, n);
    end
    tick(4);
    check("err_ok_idle", 32'h0, 32'({error_led, ok_led}));
    for (int i = 0; i < 3; i++) begin
      wr(OFS_EVENT, 32'h1 << se[i]);
      tick(2); // Let a phase begun under the old pattern reach the pin.
      hi_run(0, n);
      check("status_half", sl[i], n);
    end
    wr(OFS_EVENT, 32'h1 << EV_BIND_OK);
    tick(4);
    n = 0;
    repeat (2 * SLOW) begin
      tick(1);
      if (status_led !== 1'b1) n++;
    end
    check("bind_steady", 32'h0, n);
    wr(OFS_CTRL, 32'h2);
    tick(3);
    check("cmd_leds", 32'h3, 32'({status_led, error_led, ok_led}));
    wr(OFS_CTRL, 32'h0);
    wr(OFS_UART, 32'h5a);
    wr(OFS_UART, 32'ha5);
    for (int k = 0; k < 400 && host_uart_model_inst.rx_log.size() < 2; k++) tick(1);
    check("tx_count", 32'h2, host_uart_model_inst.rx_log.size());
    for (int i = 0; i < host_uart_model_inst.rx_log.size(); i++) begin
      check("tx_byte", i ? 32'ha5 : 32'h5a, 32'(host_uart_model_inst.rx_log[i]));
    end
    host_uart_model_inst.send_byte(8'hc3);
    tick(3 * BITL);
    rchk("rx_byte", OFS_UART, 32'h1c3);
    bus(1'b0, OFS_UART, 32'h0);
    check("rx_cleared", 32'h0, 32'(rd[8]));
    wr(OFS_CTRL, 32'h1);
    key_n <= 1'b0;
    wr(OFS_EVENT, 32'h1 << EV_SLEEP);
    tick(HOLD);
    check("key_holds", 32'h0, 32'(low_power));
    key_n <= 1'b1;
    tick(HOLD - 8);
    check("holdoff_wait", 32'h0, 32'(low_power));
    for (int k = 0; k < 30 && low_power !== 1'b1; k++) tick(1);
    tick(2);
    check("sleep_leds", 32'hf, 32'({low_power, status_led, error_led, ok_led}));
    bus(1'b0, OFS_STATUS, 32'h0);
    check("key_bits", 32'h2, (rd >> 5) & 32'h3);
    wr(OFS_EVENT, 32'h1 << EV_KEY_CLEAR);
    bus(1'b0, OFS_STATUS, 32'h0);
    check("key_clear", 32'h0, 32'(rd[6]));
    wr(OFS_EVENT, 32'h1 << EV_WAKE);
    tick(3);
    check("wake_leds", 32'h4, 32'({low_power, status_led, error_led, ok_led}));
    reset_n <= 1'b0;
    tick(6);
    check("soft_reset", 32'h2ff, 32'({soft_reset, status_led, gpio_out}));
    reset_n <= 1'b1;
    tick(6);
    check("soft_release", 32'h0, 32'(soft_reset));
    rchk("ctrl_cleared", OFS_CTRL, 32'h0);
    give_verdict();
  end
endmodule

bind module_status_and_local_io status_io_monitor #(.HOLDOFF_LEN(HOLDOFF_LEN)) status_io_monitor_inst (
  .clock(clock), .rst(rst), .address(address), .write(write), .waitrequest(waitrequest),
  .uart_tx(uart_tx), .reset_n(reset_n), .soft_reset(soft_reset), .status_led(status_led),
  .error_led(error_led), .ok_led(ok_led), .key_n(key_n), .low_power(low_power),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe));
